/* File: inc/psc_pkg.sv */
// Shared constants and carriers for the pipelined SRAM pin control block
package psc_pkg;
    // Byte lanes and lane width of the data bus
    localparam int LANES      = 4;
    localparam int LANE_W     = 8;
    localparam int DATA_W     = LANES * LANE_W;
    // Cell width of one lane in the array: data byte plus its parity bit
    localparam int CELL_W     = LANE_W + 1;
    // Address bits, the low two of which belong to the burst counter
    localparam int ADDR_W     = 21;
    localparam int BURST_W    = 2;
    // Reset values of control state
    localparam logic       RST_OP_VALID = 1'b0;
    localparam logic       RST_DRIVE    = 1'b0;
    localparam logic [1:0] RST_COUNT    = 2'h0;
    // Strap level taken when the pin is left open
    localparam logic       MODE_DEFAULT = 1'b1;
    localparam logic       MODE_INTERLEAVED = 1'b1;

    // Data pins as one word: main lanes and parity lanes
    typedef struct packed {
        logic [LANES-1:0]  parity;
        logic [DATA_W-1:0] data;
    } psc_word_t;

    // Controls sampled at a qualified rising edge
    typedef struct packed {
        logic              write_n;
        logic              advance;
        logic [LANES-1:0]  lane_sel_n;
        logic [ADDR_W-1:0] addr;
    } psc_ctrl_t;
endpackage

/* File: logic/psc_mem.sv */
`timescale 1ns/1ps
// Lane-wide storage with per-lane write enables and a registered read word
module psc_mem
    import psc_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 en_i,
    input  wire logic                 we_i,
    input  wire logic [LANES-1:0]     lane_we_i,
    input  wire logic [AW-1:0]        addr_i,
    input  wire psc_pkg::psc_word_t   wdata_i,
    output      psc_pkg::psc_word_t   rdata_o
);
    import psc_pkg::*;

    // One array per lane, each cell holds a data byte and its parity bit
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [CELL_W-1:0] cells [0:(1<<AW)-1];   // Lane storage
        logic [CELL_W-1:0] rd_reg;                 // Registered read cell

        // Write only the enabled lane; read registers the cell on every edge with en_i high
        always_ff @(posedge sys_clk_i) begin
            if (en_i) begin
                if (we_i && lane_we_i[g]) begin
                    cells[addr_i] <= {wdata_i.parity[g], wdata_i.data[g*LANE_W +: LANE_W]};
                end
                rd_reg <= cells[addr_i];
            end
        end

        // Split the cell back onto the word
        assign rdata_o.parity[g]                  = rd_reg[LANE_W];
        assign rdata_o.data[g*LANE_W +: LANE_W]   = rd_reg[LANE_W-1:0];
    end
endmodule

/* File: logic/psc_top.sv */
`timescale 1ns/1ps
// What this block does
// - Register inputs only on qualified rising edges; the strap on any edge in reset
// - Qualify high holds every state, no deselect
// - Selected when first low, second high, third low
// - Output drive low enables pins, high floats
// - Float on write data, emerging, and deselected
// - Input pins captured on the rising edge
// - Read data appears one qualified cycle later
// - Parity lanes act like data lanes
// - Strap high interleaved, strap low linear
// - Open strap defaults high, interleaved order
// - Write strobe sampled low starts a write
// - Lane select with strobe writes its lane
// - Burst counter uses two lowest address bits
module psc_top
    import psc_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 clock_qualify_n_i,
    input  wire logic                 chip_sel_first_n_i,
    input  wire logic                 chip_sel_second_i,
    input  wire logic                 chip_sel_third_n_i,
    input  wire logic                 write_n_i,
    input  wire logic                 advance_or_load_i,
    input  wire logic [LANES-1:0]     lane_write_sel_n_i,
    input  wire logic [AW-1:0]        addr_i,
    input  wire logic                 out_drive_n_i,
    input  wire logic                 burst_mode_i,
    input  wire psc_pkg::psc_word_t   pins_i,
    output      psc_pkg::psc_word_t   pins_o,
    output      logic                 pins_oe_o
);
    import psc_pkg::*;

    // Qualified edge: every state update below except reset and the strap capture is gated by it
    logic qual;
    assign qual = !clock_qualify_n_i;

    // Device selected by the three chip selects together
    logic selected;
    assign selected = !chip_sel_first_n_i && chip_sel_second_i && !chip_sel_third_n_i;

    // Address phase state
    logic [AW-1:BURST_W]  addr_hi_reg,  addr_hi_next;   // Upper address of the burst
    logic [BURST_W-1:0]   start_reg,    start_next;     // Starting low bits
    logic [BURST_W-1:0]   count_reg,    count_next;     // Advances since load
    logic                 op_valid_reg, op_valid_next;  // An access is in progress
    logic                 op_write_reg, op_write_next;  // Access type kept for the burst
    logic [LANES-1:0]     lanes_n_reg,  lanes_n_next;   // Lane selects of this beat
    // Data phase state
    logic                 drive_reg,    drive_next;     // Read data on the pins now
    // Burst order strap, caught while reset is held
    logic                 mode_reg,     mode_next;

    // Low address bits produced by the burst counter
    logic [BURST_W-1:0]   low_addr;
    logic [AW-1:0]        core_addr;
    psc_word_t            rd_word;

    // Burst order: linear adds the count, interleaved flips bits by it
    always_comb begin
        if (mode_reg == MODE_INTERLEAVED) begin
            low_addr = start_reg ^ count_reg;
        end else begin
            low_addr = start_reg + count_reg;
        end
    end
    assign core_addr = {addr_hi_reg, low_addr};

    // Next state of the address phase and the data phase
    always_comb begin
        addr_hi_next  = addr_hi_reg;
        start_next    = start_reg;
        count_next    = count_reg;
        op_valid_next = op_valid_reg;
        op_write_next = op_write_reg;
        lanes_n_next  = lanes_n_reg;
        drive_next    = drive_reg;
        mode_next     = mode_reg;
        if (rst_i) begin
            // Strap is sampled while held in reset; it must then stay put
            mode_next = burst_mode_i;
        end else if (qual) begin
            // The beat now in the address phase moves to the data phase
            drive_next = op_valid_reg && !op_write_reg;
            if (advance_or_load_i) begin
                // Step the counter whatever the chip selects say
                count_next   = count_reg + 2'h1;
                lanes_n_next = lane_write_sel_n_i;
            end else if (selected) begin
                // Load a new access; strobe picks read or write
                addr_hi_next  = addr_i[AW-1:BURST_W];
                start_next    = addr_i[BURST_W-1:0];
                count_next    = RST_COUNT;
                op_valid_next = 1'b1;
                op_write_next = !write_n_i;
                lanes_n_next  = lane_write_sel_n_i;
            end else begin
                // Deselect is pipelined like any other access
                op_valid_next = 1'b0;
            end
        end
        // Without a qualified edge every value is held: a stretched cycle
    end

    // Register the state; synchronous reset
    // Reset clears only the access pipeline, never the array: a reset in
    // mid-run keeps stored data, so software sees old contents afterwards
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            addr_hi_reg  <= '0;
            start_reg    <= '0;
            count_reg    <= RST_COUNT;
            op_valid_reg <= RST_OP_VALID;
            op_write_reg <= 1'b0;
            lanes_n_reg  <= '1;
            drive_reg    <= RST_DRIVE;
        end else begin
            addr_hi_reg  <= addr_hi_next;
            start_reg    <= start_next;
            count_reg    <= count_next;
            op_valid_reg <= op_valid_next;
            op_write_reg <= op_write_next;
            lanes_n_reg  <= lanes_n_next;
            drive_reg    <= drive_next;
        end
        mode_reg <= mode_next;
    end

    // Core: a write beat stores the pins at the rise ending its data cycle,
    // a read beat registers the word that the pins show in the next cycle
    psc_mem #(
        .AW        (AW)
    ) u_mem (
        .sys_clk_i (sys_clk_i),
        .en_i      (qual && !rst_i),
        .we_i      (op_valid_reg && op_write_reg),
        .lane_we_i (~lanes_n_reg),
        .addr_i    (core_addr),
        .wdata_i   (pins_i),
        .rdata_o   (rd_word)
    );

    // Pins drive only in a read data cycle and with output drive low;
    // a write data cycle, a deselect and the first cycle out of it all
    // leave drive_reg low, so the pins float whatever the drive input says
    assign pins_oe_o = drive_reg && !out_drive_n_i;
    assign pins_o    = rd_word;

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Suspended edge changes nothing
    hold_on_suspend_a: assert property (
        clock_qualify_n_i |=>
            $stable(drive_reg) && $stable(count_reg) && $stable(op_valid_reg))
        else $error("state changed on a suspended edge");
    // Select decode
    select_decode_a: assert property (
        qual && !advance_or_load_i && !selected |=> !op_valid_reg)
        else $error("unselected load started an access");
    // Output drive input floats the pins
    drive_input_a: assert property (
        out_drive_n_i |-> !pins_oe_o)
        else $error("pins driven with output drive high");
    // Write data cycle floats the pins
    write_float_a: assert property (
        op_valid_reg && op_write_reg && qual |=> !pins_oe_o)
        else $error("pins driven after a write data cycle");
    // Read drives one qualified cycle after the load
    read_pipe_a: assert property (
        qual && selected && !advance_or_load_i && write_n_i
        ##1 qual && !out_drive_n_i |=> pins_oe_o)
        else $error("read data not driven one cycle later");
    // Deselect floats after the next rise
    deselect_float_a: assert property (
        qual && !selected && !advance_or_load_i ##1 qual |=> !pins_oe_o)
        else $error("pins driven after deselect");
    // Linear burst steps by one
    linear_step_a: assert property (
        qual && advance_or_load_i && mode_reg != MODE_INTERLEAVED |=>
            low_addr == $past(low_addr) + 2'h1)
        else $error("linear burst did not step by one");
    // Lane enables follow the lane selects on every advance beat, read or write
    lane_enable_a: assert property (
        qual && advance_or_load_i |=> lanes_n_reg == $past(lane_write_sel_n_i))
        else $error("lane selects not taken with the beat");
    // A selected load opens an access with the counter cleared
    load_opens_a: assert property (
        qual && !advance_or_load_i && selected |=> op_valid_reg && count_reg == RST_COUNT)
        else $error("selected load did not open an access");
endmodule

/* File: testbench/psc_ctl_model.sv */
`timescale 1ns/1ps
// Memory controller side of the data pins
module psc_ctl_model
    import psc_pkg::*;
(
    input  wire logic               sys_clk_i,
    input  wire logic               drive_i,
    input  wire psc_pkg::psc_word_t wdata_i,
    input  wire logic               dev_oe_i,
    input  wire psc_pkg::psc_word_t dev_word_i,
    output      psc_pkg::psc_word_t wire_o
);
    import psc_pkg::*;

    psc_word_t last_reg; // Last wire level
    // Remember the wire so a released bus never shows a stale copy
    always_ff @(posedge sys_clk_i) begin
        last_reg <= wire_o;
    end
    // Device, controller or floating; float shows the inverse of the last level
    always_comb begin
        if (dev_oe_i) begin
            wire_o = dev_word_i;
        end else if (drive_i) begin
            wire_o = wdata_i;
        end else begin
            wire_o = ~last_reg;
        end
    end
endmodule

/* File: testbench/psc_top_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the pin control block
module psc_top_tb;
    import psc_pkg::*;
    localparam int AW = 6; // Small array keeps the run short
    logic          sys_clk_i = 1'b0;
    logic          rst_i     = 1'b1;
    logic          qual_n    = 1'b0;
    logic [2:0]    cs        = 3'b110; // First_n, second, third_n
    logic          write_n   = 1'b1;
    logic          adv       = 1'b0;
    logic [3:0]    lanes_n   = 4'hf;
    logic [AW-1:0] addr      = '0;
    logic          drive_n   = 1'b0;
    logic          mode      = MODE_DEFAULT; // Open strap level
    logic          drv       = 1'b0;
    psc_word_t     wd        = '0;
    psc_word_t     pins_i;
    psc_word_t     pins_o;
    logic          pins_oe_o;
    psc_word_t     mem_exp [64]; // Expected array contents
    int            err_total = 0;
    int            n_tests   = 0;
    psc_top #(.AW(AW)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clock_qualify_n_i(qual_n),
        .chip_sel_first_n_i(cs[2]), .chip_sel_second_i(cs[1]), .chip_sel_third_n_i(cs[0]),
        .write_n_i(write_n), .advance_or_load_i(adv), .lane_write_sel_n_i(lanes_n),
        .addr_i(addr), .out_drive_n_i(drive_n), .burst_mode_i(mode), .pins_i(pins_i),
        .pins_o(pins_o), .pins_oe_o(pins_oe_o));
    psc_ctl_model ctl (.sys_clk_i(sys_clk_i), .drive_i(drv), .wdata_i(wd),
        .dev_oe_i(pins_oe_o), .dev_word_i(pins_o), .wire_o(pins_i));
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    task automatic finish_test();
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strap only moves while reset is held, never in operation
    task automatic do_reset(input int n, input logic m);
        @(negedge sys_clk_i);
        rst_i = 1'b1;
        mode = m;
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
    endtask
    // One beat set at the falling edge; outputs looked at just after the rise
    task automatic op(input logic [2:0] c, input logic w, input logic a,
                      input logic [3:0] l, input logic [AW-1:0] ad, input logic d);
        @(negedge sys_clk_i);
        cs = c;
        write_n = w;
        adv = a;
        lanes_n = l;
        addr = ad;
        drv = d;
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(input logic [2:0] c, input logic [AW-1:0] a, input logic [3:0] l,
                      input psc_word_t w);
        op(c, 1'b0, 1'b0, l, a, 1'b0);
        chk(pins_oe_o, 1'b0);
        wd = w;
        op(3'b110, 1'b1, 1'b0, 4'hf, '0, 1'b1);
        chk(pins_oe_o, 1'b0);
        for (int g = 0; g < LANES; g++) begin
            if (c == 3'b010 && !l[g]) begin
                mem_exp[a].data[8*g +: 8] = w.data[8*g +: 8];
                mem_exp[a].parity[g] = w.parity[g];
            end
        end
    endtask
    task automatic rd(input logic [AW-1:0] a);
        op(3'b010, 1'b1, 1'b0, 4'hf, a, 1'b0);
        op(3'b110, 1'b1, 1'b0, 4'hf, '0, 1'b0);
        chk(pins_oe_o, 1'b1);
        chk(pins_o, mem_exp[a]);
    endtask
    // Full words, then a partial lane write over one of them
    task automatic t_rw();
        for (int i = 0; i < 5; i++) begin
            wr(3'b010, AW'(i < 4 ? i : 9), 4'h0, {4'(i) ^ 4'h5, 32'hc3a50000 | 32'(i)});
            rd(AW'(i < 4 ? i : 9));
        end
        wr(3'b010, 6'h09, 4'ha, 36'h5_1122_3344);
        rd(6'h09);
    endtask
    // Each of the three patterns with one select wrong must not write; deselect floats a beat later
    task automatic t_cs();
        logic [2:0] bad [3] = '{3'b110, 3'b000, 3'b011};
        for (int i = 0; i < 3; i++) begin
            wr(bad[i], 6'h09, 4'h0, 36'ha_dead_beef);
            rd(6'h09);
            op(3'b110, 1'b1, 1'b0, 4'hf, '0, 1'b0);
            chk(pins_oe_o, 1'b0);
        end
    endtask
    // Suspended edges hold the read word; output drive floats it at once
    task automatic t_hold();
        rd(6'h02);
        @(negedge sys_clk_i);
        qual_n = 1'b1;
        repeat (3) op(3'b010, 1'b0, 1'b0, 4'h0, '0, 1'b0);
        chk(pins_oe_o, 1'b1);
        chk(pins_o, mem_exp[2]);
        @(negedge sys_clk_i);
        drive_n = 1'b1;
        #1 chk(pins_oe_o, 1'b0);
        @(negedge sys_clk_i);
        drive_n = 1'b0;
        #1 chk(pins_oe_o, 1'b1);
        // Idle beat must stand before edges count again, or the held
        // write load would open a stray write when qualify returns
        @(negedge sys_clk_i);
        qual_n = 1'b0;
        cs = 3'b110;
        write_n = 1'b1;
        lanes_n = 4'hf;
        @(posedge sys_clk_i);
        #1 chk(pins_oe_o, 1'b0);
    endtask
    // Four-beat read bursts from every start, the first after a reset, the rest after a deselect
    task automatic t_burst(input logic m);
        do_reset(2, m);
        for (int s = 0; s < 4; s++) begin
            op(3'b010, 1'b1, 1'b0, 4'hf, AW'(s), 1'b0);
            for (int k = 0; k < 4; k++) begin
                op(k < 3 ? 3'b010 : 3'b110, 1'b1, k < 3, 4'hf, '0, 1'b0);
                chk(pins_oe_o, 1'b1);
                chk(pins_o, mem_exp[m ? (s ^ k) : ((s + k) % 4)]);
            end
        end
    endtask
    // Linear write burst from start one; lanes retaken each beat, then read back
    task automatic t_wburst();
        logic [3:0] ln;
        wr(3'b010, 6'h04, 4'h0, 36'h0_0f0f_0f0f);
        op(3'b010, 1'b0, 1'b0, 4'h0, 6'h05, 1'b0);
        for (int k = 0; k < 4; k++) begin
            ln = k == 3 ? 4'hc : 4'h0;
            wd = 36'h9_6b00_7700 + 36'(k);
            op(k < 3 ? 3'b010 : 3'b110, 1'b1, k < 3, k == 2 ? 4'hc : 4'h0, '0, 1'b1);
            chk(pins_oe_o, 1'b0);
            for (int g = 0; g < LANES; g++) begin
                if (!ln[g]) begin
                    mem_exp[4 + (1 + k) % 4].data[8*g +: 8] = wd.data[8*g +: 8];
                    mem_exp[4 + (1 + k) % 4].parity[g] = wd.parity[g];
                end
            end
        end
        for (int a = 4; a < 8; a++) begin
            rd(AW'(a));
        end
    endtask
    initial begin
        do_reset(12, 1'b1);
        t_rw();
        t_cs();
        t_hold();
        t_burst(1'b1);
        t_burst(1'b0);
        t_wburst();
        finish_test();
    end
    initial begin
        #200000;
        err_total++;
        finish_test();
    end
endmodule
